// >>> rtl/tmlh_pkg.sv
// Shared constants and carrier types for the temperature limit and hottest-of block
package tmlh_pkg;
    // Channel count and temperature word width (8 integer bits, 3 fraction bits)
    localparam int          NCH = 8;
    localparam int          TW  = 11;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_MAIN_STAT  = 8'h02;
    localparam logic [7:0]  IDX_HOT_HI     = 8'h32;
    localparam logic [7:0]  IDX_HOT_LO     = 8'h33;
    localparam logic [7:0]  IDX_HOT_STAT   = 8'h34;
    localparam logic [7:0]  IDX_CRIT_STAT  = 8'h37;
    localparam logic [7:0]  IDX_REC_DIS    = 8'h39;
    localparam logic [7:0]  IDX_MAX_SEL    = 8'h3A;
    localparam logic [7:0]  IDX_CHAN_SETUP = 8'h3B;

    // Reset values
    localparam logic [7:0]  RST_REC_DIS    = 8'h00;
    localparam logic [7:0]  RST_MAX_SEL    = 8'h00;
    localparam logic [7:0]  RST_CHAN_SETUP = 8'h00;

    // Writable bits of each configuration register
    localparam logic [7:0]  MASK_REC_DIS    = 8'hFE;
    localparam logic [7:0]  MASK_MAX_SEL    = 8'hFF;
    localparam logic [7:0]  MASK_CHAN_SETUP = 8'h8E;

    // Field positions in the channel setup register
    localparam int          BIT_REMEMBER = 7;
    localparam int          BIT_PAIR67   = 3;
    localparam int          BIT_PAIR45   = 2;
    localparam int          BIT_PAIR23   = 1;

    // Field positions in the main status register
    localparam int          BIT_HOT_CHG  = 0;
    localparam int          BIT_CRIT_SUM = 1;

    // Channels monitored whatever the pairing: internal, ext1, ext2, ext4, ext6
    localparam logic [7:0]  ALWAYS_ACTIVE = 8'h57;

    // Hottest result when nothing is selected
    localparam logic [7:0]  HOT_EMPTY_HI = 8'h80;
    localparam logic [2:0]  HOT_EMPTY_LO = 3'h0;

    // One conversion result per channel, with its valid strobe
    typedef struct packed {
        logic [NCH-1:0][TW-1:0] temp;
        logic [NCH-1:0]         valid;
    } tmlh_meas_t;

    // Critical limits, hysteresis and consecutive count from the limit block
    typedef struct packed {
        logic [NCH-1:0][7:0]    limit;
        logic [7:0]             hyst;
        logic [3:0]             consec;
    } tmlh_lim_t;

    // Outcome of one hottest-of comparison
    typedef struct packed {
        logic                   any;
        logic [NCH-1:0]         onehot;
        logic [TW-1:0]          temp;
    } tmlh_hot_t;
endpackage

// >>> rtl/tmlh_crit_chan.sv
// Critical-limit flag of one channel with consecutive count and hysteresis
module tmlh_crit_chan (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sample,
    input  wire logic [7:0] temp_hi,
    input  wire logic [7:0] limit,
    input  wire logic [7:0] hyst,
    input  wire logic [3:0] consec,
    output logic            flag
);
    logic [3:0] cnt_ff;     // Readings in a row at or above limit
    logic       flag_ff;    // Sticky critical flag
    logic       over;       // Reading meets or exceeds limit
    logic       below;      // Reading under limit minus hysteresis
    logic [9:0] clr_lvl;    // Widened so a large hysteresis cannot wrap
    logic [3:0] target;     // Count needed, zero treated as one

    assign over    = $signed(temp_hi) >= $signed(limit);
    assign clr_lvl = 10'({{2{limit[7]}}, limit} - {2'h0, hyst});
    assign below   = $signed({{2{temp_hi[7]}}, temp_hi}) < $signed(clr_lvl);
    assign target  = (consec == 4'h0) ? 4'h1 : consec;
    assign flag    = flag_ff;

    // Run length counter, saturating, restarts on any reading under limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
        end else if (sample) begin
            if (!over) begin
                cnt_ff <= 4'h0;
            end else if (cnt_ff != 4'hF) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    // Flag sets on the run length, clears itself below the hysteresis level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        // [RULE1] Set after enough readings
        end else if (sample && over && ((cnt_ff + 4'h1) >= target)) begin
            flag_ff <= 1'b1;
        // [RULE5] Hysteresis based clear
        end else if (sample && below) begin
            flag_ff <= 1'b0;
        end
    end

    flag_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        $rose(flag_ff) |-> $past(sample) && $past(over)
            && (($past(cnt_ff) + 4'h1) >= $past(target)))
        else $error("critical flag rose without enough readings");

    flag_fall_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        $fell(flag_ff) |-> $past(sample) && $past(below))
        else $error("critical flag fell above hysteresis level");
endmodule

// >>> rtl/tmlh_hottest.sv
// Combinational hottest-of search over the selected channels
module tmlh_hottest (
    input  wire tmlh_pkg::tmlh_meas_t meas,
    input  wire logic [7:0]           select,
    output tmlh_pkg::tmlh_hot_t       result
);
    // Walk channels in measurement order, internal first
    always_comb begin
        result.any    = 1'b0;
        result.onehot = 8'h00;
        result.temp   = {tmlh_pkg::HOT_EMPTY_HI, tmlh_pkg::HOT_EMPTY_LO};
        for (int i = 0; i < tmlh_pkg::NCH; i++) begin
            // [RULE16] Strictly greater keeps earlier channel on tie
            if (select[i] && (!result.any
                    || ($signed(meas.temp[i]) > $signed(result.temp)))) begin
                result.any    = 1'b1;
                result.onehot = 8'(1 << i);
                result.temp   = meas.temp[i];
            end
        end
    end
endmodule

// >>> rtl/tmlh_top.sv
// Top of the critical-limit status, correction, hottest-of and pairing logic
//
// Notes on behaviour
// [RULE1] Flag sets after N consecutive readings over limit
// [RULE2] Status byte: ext7..ext1 bits 7..1, internal bit 0
// [RULE3] Any channel flag sets the summary bit
// [RULE4] Reading critical status clears nothing
// [RULE5] Flag clears below limit minus hysteresis
// [RULE6] Summary clears only when all flags clear
// [RULE7] Correction disable bits 7..1, default enabled
// [RULE8] Select bits 7..1 include external channels
// [RULE9] Select bit 0 includes internal channel
// [RULE10] Comparison runs at every cycle end
// [RULE11] Remember mode flags a changed hottest channel
// [RULE12] Setup bit 3 pairs channels six, seven
// [RULE13] Setup bit 2 pairs channels four, five
// [RULE14] Setup bit 1 pairs channels two, three
// [RULE15] Empty selection reports high byte 80h
// [RULE16] Ties resolved by measurement order
// [RULE17] Unused config bits read zero, ignore writes
//
// Chosen here: the APB register port.
module tmlh_top (
    // Clock, reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,

    // Register bus
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [9:0]           paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,

    // Readings
    input  wire tmlh_pkg::tmlh_meas_t meas,
    input  wire tmlh_pkg::tmlh_lim_t  lim,
    input  wire logic                 cycle_done,

    // Controls out
    output logic [7:1]                ext_correction_disable,
    output logic [7:0]                chan_active,
    output logic                      pair6_7_antiparallel,
    output logic                      pair4_5_antiparallel,
    output logic                      pair2_3_antiparallel,

    // Status out
    output logic [7:0]                critical_flags,
    output logic                      critical_summary,
    output logic                      max_changed
);
    // Register selector codes used by read and write decode
    typedef enum logic [3:0] {
        TMLH_R_NONE  = 4'h0,
        TMLH_R_MAIN  = 4'h1,
        TMLH_R_HOTHI = 4'h2,
        TMLH_R_HOTLO = 4'h3,
        TMLH_R_HOTST = 4'h4,
        TMLH_R_CRIT  = 4'h5,
        TMLH_R_REC   = 4'h6,
        TMLH_R_SEL   = 4'h7,
        TMLH_R_SETUP = 4'h8
    } tmlh_reg_t;

    // Map a byte address onto a register, misaligned counts as unmapped
    function automatic tmlh_reg_t tmlh_decode(input logic [9:0] addr);
        tmlh_reg_t r;
        r = TMLH_R_NONE;

        // Word aligned only
        if (addr[1:0] == 2'h0) begin
            case (addr[9:2])
                tmlh_pkg::IDX_MAIN_STAT:  r = TMLH_R_MAIN;
                tmlh_pkg::IDX_HOT_HI:     r = TMLH_R_HOTHI;
                tmlh_pkg::IDX_HOT_LO:     r = TMLH_R_HOTLO;
                tmlh_pkg::IDX_HOT_STAT:   r = TMLH_R_HOTST;
                tmlh_pkg::IDX_CRIT_STAT:  r = TMLH_R_CRIT;
                tmlh_pkg::IDX_REC_DIS:    r = TMLH_R_REC;
                tmlh_pkg::IDX_MAX_SEL:    r = TMLH_R_SEL;
                tmlh_pkg::IDX_CHAN_SETUP: r = TMLH_R_SETUP;
                default:                  r = TMLH_R_NONE;
            endcase
        end

        return r;
    endfunction

    // Software configuration registers
    logic [7:0]          rec_ff;        // Correction disable per channel
    logic [7:0]          sel_ff;        // Hottest-of inclusion per channel
    logic [7:0]          setup_ff;      // Remember and pairing controls

    // Bus side state
    logic [31:0]         rdata_ff;      // Read data captured in setup cycle
    logic                err_ff;        // Unmapped access seen in setup cycle

    // Hottest-of state
    tmlh_pkg::tmlh_hot_t hot_cmb;       // Search over current readings
    tmlh_pkg::tmlh_hot_t hot_ff;        // Result of last completed cycle

    // Remember mode
    logic [7:0]          last_hot_ff;   // Remembered hottest channel
    logic                last_vld_ff;   // A hottest channel is remembered
    logic                hot_chg_ff;    // Sticky hottest-changed status

    // Decoded strobes
    tmlh_reg_t           reg_sel;       // Register addressed now
    logic                acc_done;      // Access phase completes this edge
    logic                wr_ok;         // Write of byte lane zero
    logic [7:0]          wbyte;         // Written byte

    // Status events
    logic                hot_chg_set;   // Hottest channel moved this cycle
    logic                hot_chg_clr;   // Status read completes this cycle

    // Channel side
    logic [7:0]          sample;        // Reading strobes of active channels
    logic [7:0]          crit_flags;    // Per-channel critical flags

    // Address decode
    assign reg_sel  = tmlh_decode(paddr);

    // No wait states: read data was already registered in setup
    assign pready   = psel && penable;
    assign pslverr  = pready && err_ff;
    assign prdata   = rdata_ff;

    // Write strobe, lane zero only
    assign acc_done = psel && penable;
    assign wr_ok    = acc_done && pwrite && pstrb[0];
    assign wbyte    = pwdata[7:0];

    // Pairing controls and the channels they bring in
    // [RULE12] Pair six and seven
    assign pair6_7_antiparallel = setup_ff[tmlh_pkg::BIT_PAIR67];

    // [RULE13] Pair four and five
    assign pair4_5_antiparallel = setup_ff[tmlh_pkg::BIT_PAIR45];

    // [RULE14] Pair two and three
    assign pair2_3_antiparallel = setup_ff[tmlh_pkg::BIT_PAIR23];

    // Odd channels 3, 5, 7 idle unless paired
    assign chan_active = tmlh_pkg::ALWAYS_ACTIVE
                       | {pair6_7_antiparallel, 1'b0,
                          pair4_5_antiparallel, 1'b0,
                          pair2_3_antiparallel, 3'h0};

    // [RULE7] Correction disable drive
    assign ext_correction_disable = rec_ff[7:1];

    // Readings of an unmonitored channel are ignored
    assign sample = meas.valid & chan_active;

    // One flag per channel, bit order matches the status byte
    generate
        for (genvar g = 0; g < tmlh_pkg::NCH; g++) begin : g_crit
            tmlh_crit_chan u_crit (
                .pclk    (pclk),
                .presetn (presetn),
                .sample  (sample[g]),
                .temp_hi (meas.temp[g][10:3]),
                .limit   (lim.limit[g]),
                .hyst    (lim.hyst),
                .consec  (lim.consec),
                .flag    (crit_flags[g])
            );
        end
    endgenerate

    // [RULE2] Status byte bit order
    assign critical_flags   = crit_flags;

    // [RULE3] Summary follows the channel flags
    // [RULE6] Clears with last flag
    assign critical_summary = |crit_flags;

    // Sticky changed bit out
    assign max_changed      = hot_chg_ff;

    // Hottest-of search; inactive channels never take part
    // [RULE9] Internal bit too
    tmlh_hottest u_hot (
        .meas   (meas),
        .select (sel_ff & chan_active),
        .result (hot_cmb)
    );

    // Correction disable register, bit 0 has no channel behind it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_ff <= tmlh_pkg::RST_REC_DIS;
        // [RULE17] Unused bits stay zero
        end else if (wr_ok && (reg_sel == TMLH_R_REC)) begin
            rec_ff <= wbyte & tmlh_pkg::MASK_REC_DIS;
        end
    end

    // Hottest-of selection register, every bit used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= tmlh_pkg::RST_MAX_SEL;
        // [RULE8] External and internal inclusion
        end else if (wr_ok && (reg_sel == TMLH_R_SEL)) begin
            sel_ff <= wbyte & tmlh_pkg::MASK_MAX_SEL;
        end
    end

    // Channel setup register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_ff <= tmlh_pkg::RST_CHAN_SETUP;
        // [RULE17] Reserved setup bits
        end else if (wr_ok && (reg_sel == TMLH_R_SETUP)) begin
            setup_ff <= wbyte & tmlh_pkg::MASK_CHAN_SETUP;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
            err_ff   <= 1'b0;
        end else if (psel && !penable) begin
            err_ff   <= (reg_sel == TMLH_R_NONE);
            rdata_ff <= 32'h0000_0000;

            // Upper bytes stay zero
            if (!pwrite) begin
                case (reg_sel)
                    TMLH_R_MAIN:  rdata_ff[7:0] <= {6'h00, critical_summary, hot_chg_ff};
                    TMLH_R_HOTHI: rdata_ff[7:0] <= hot_ff.temp[10:3];
                    TMLH_R_HOTLO: rdata_ff[7:0] <= {hot_ff.temp[2:0], 5'h00};
                    TMLH_R_HOTST: rdata_ff[7:0] <= hot_ff.onehot;
                    // [RULE4] Plain read, no side effect
                    TMLH_R_CRIT:  rdata_ff[7:0] <= crit_flags;
                    TMLH_R_REC:   rdata_ff[7:0] <= rec_ff;
                    TMLH_R_SEL:   rdata_ff[7:0] <= sel_ff;
                    TMLH_R_SETUP: rdata_ff[7:0] <= setup_ff;
                    default:      rdata_ff[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // [RULE10] Latch result at cycle end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_ff <= '{any: 1'b0, onehot: 8'h00,
                        temp: {tmlh_pkg::HOT_EMPTY_HI, tmlh_pkg::HOT_EMPTY_LO}};
        end else if (cycle_done) begin
            // [RULE15] Empty result from search
            hot_ff <= hot_cmb;
        end
    end

    // Remembered channel, kept only in remember mode and only for a real result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_hot_ff <= 8'h00;
            last_vld_ff <= 1'b0;
        end else if (!setup_ff[tmlh_pkg::BIT_REMEMBER]) begin
            // Leaving remember mode forgets, so re-entry cannot false-trigger
            last_vld_ff <= 1'b0;
        end else if (cycle_done && hot_cmb.any) begin
            // [RULE11] Store hottest channel
            last_hot_ff <= hot_cmb.onehot;
            last_vld_ff <= 1'b1;
        end
    end

    // [RULE11] Detect a moved hottest channel
    assign hot_chg_set = cycle_done && hot_cmb.any && last_vld_ff
                      && setup_ff[tmlh_pkg::BIT_REMEMBER]
                      && (hot_cmb.onehot != last_hot_ff);

    // Clear only a set bit that this read returned, so no event is lost
    assign hot_chg_clr = acc_done && !pwrite && (reg_sel == TMLH_R_MAIN)
                      && rdata_ff[tmlh_pkg::BIT_HOT_CHG];

    // Sticky changed bit; a new event beats a status read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_chg_ff <= 1'b0;
        end else if (hot_chg_set) begin
            // Event first
            hot_chg_ff <= 1'b1;
        end else if (hot_chg_clr) begin
            // Read clears
            hot_chg_ff <= 1'b0;
        end
    end

    summary_or_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        critical_summary == (|crit_flags))
        else $error("summary bit disagrees with channel flags");

    read_keeps_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        (acc_done && !pwrite && (reg_sel == TMLH_R_CRIT) && (sample == 8'h00))
            |=> $stable(crit_flags))
        else $error("critical status read changed the flags");

    rec_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        (wr_ok && (reg_sel == TMLH_R_REC))
            |=> (ext_correction_disable == $past(pwdata[7:1])) && !rec_ff[0])
        else $error("correction disable did not follow write");

    sel_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        (wr_ok && (reg_sel == TMLH_R_SEL)) |=> (sel_ff == $past(pwdata[7:0])))
        else $error("selection register did not follow write");

    hot_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        cycle_done |=> (hot_ff == $past(hot_cmb)))
        else $error("hottest result not updated at cycle end");

    hot_empty_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
        (cycle_done && ((sel_ff & chan_active) == 8'h00))
            |=> (hot_ff.temp[10:3] == 8'h80) && (hot_ff.onehot == 8'h00))
        else $error("empty selection did not report 80h");

    hot_change_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        $rose(hot_chg_ff) |-> $past(setup_ff[7]) && $past(cycle_done)
            && ($past(hot_cmb.onehot) != $past(last_hot_ff)))
        else $error("changed bit rose without a moved channel");

    pair_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        (chan_active[7] == setup_ff[3]) && (chan_active[5] == setup_ff[2])
            && (chan_active[3] == setup_ff[1]) && chan_active[6] && chan_active[4])
        else $error("active channels disagree with pairing");

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        (setup_ff[6:4] == 3'h0) && !setup_ff[0] && !rec_ff[0])
        else $error("reserved configuration bit set");
endmodule

// >>> dv/tmlh_host_model.sv
// APB host model that reaches the block's registers
module tmlh_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Expected {error, data} of each read, oldest first
    logic [32:0] exp_q[$];
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
    end
    // Setup cycle, then access held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                        input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= d;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for pready; the bench watchdog ends a dead wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write one register word
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st);
        xfer(1'b1, idx, d, st);
    endtask
    // Read one word, noting what it should return
    task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic err);
        exp_q.push_back({err, e});
        xfer(1'b0, idx, 32'h0, 4'h0);
    endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the limit status and hottest-of block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_done;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  pstrb;
    tmlh_pkg::tmlh_meas_t meas;
    tmlh_pkg::tmlh_lim_t  lim;
    logic [7:1] ext_correction_disable;
    logic [7:0] chan_active, critical_flags, exp8, oh, hi, rem, act, sel;
    logic pair6_7_antiparallel, pair4_5_antiparallel, pair2_3_antiparallel;
    logic critical_summary, max_changed, chg;
    int n_fail = 0;
    int compares = 0;
    // Reset table: index and value
    logic [7:0] ridx [8] = '{8'h02, 8'h32, 8'h33, 8'h34, 8'h37, 8'h39, 8'h3A, 8'h3B};
    logic [7:0] rrst [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Config registers and their writable bits
    logic [7:0] cidx [3] = '{8'h39, 8'h3A, 8'h3B};
    logic [7:0] cmsk [3] = '{tmlh_pkg::MASK_REC_DIS, tmlh_pkg::MASK_MAX_SEL,
                             tmlh_pkg::MASK_CHAN_SETUP};
    logic [7:0] cfg [3];
    // Fixed temperatures, with a tie on ext1 and ext2 and a negative ext5
    logic [7:0] tv [8] = '{8'h19, 8'h1E, 8'h1E, 8'h0A, 8'h28, 8'hFB, 8'h0C, 8'h23};
    logic [7:0] sels [7] = '{8'h00, 8'h06, 8'h05, 8'h01, 8'hA0, 8'h20, 8'h30};

    tmlh_host_model host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
    tmlh_top tmlh_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .meas(meas), .lim(lim), .cycle_done(cycle_done),
        .ext_correction_disable(ext_correction_disable), .chan_active(chan_active),
        .pair6_7_antiparallel(pair6_7_antiparallel), .pair4_5_antiparallel(pair4_5_antiparallel),
        .pair2_3_antiparallel(pair2_3_antiparallel), .critical_flags(critical_flags),
        .critical_summary(critical_summary), .max_changed(max_changed));

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] e);
        compares++;
        if (seen !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask
    // Read monitor: oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && host_inst.exp_q.size() > 0) begin
            chk("read", {pslverr, prdata}, host_inst.exp_q.pop_front());
        end
    end
    // One reading on one channel, flag settled after
    task automatic rdg(input int ch, input logic [7:0] t);
        @(posedge pclk);
        meas.temp[ch]  <= {t, 3'h0};
        meas.valid[ch] <= 1'b1;
        @(posedge pclk);
        meas.valid[ch] <= 1'b0;
        #1;
    endtask
    // End of a conversion cycle
    task automatic conv();
        @(posedge pclk);
        cycle_done <= 1'b1;
        @(posedge pclk);
        cycle_done <= 1'b0;
        #1;
    endtask
    // Counts and verdict
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far past a normal run
    initial begin
        #200us;
        n_fail++;
        end_sim();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hF2B9));
        presetn = 1'b0;
        meas = '0;
        lim = '0;
        cycle_done = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        for (int k = 0; k < 8; k++) host_inst.rd(ridx[k], {24'h0, rrst[k]}, 1'b0);
        $display("test reset done");
        // Random writes, unused bits dropped
        for (int k = 0; k < 3; k++) begin
            d = $urandom;
            host_inst.wr(cidx[k], d, 4'hF);
            cfg[k] = d[7:0] & cmsk[k];
            host_inst.rd(cidx[k], {24'h0, cfg[k]}, 1'b0);
        end
        chk("corr", ext_correction_disable, cfg[0][7:1]);
        chk("p67", pair6_7_antiparallel, cfg[2][3]);
        chk("p45", pair4_5_antiparallel, cfg[2][2]);
        chk("p23", pair2_3_antiparallel, cfg[2][1]);
        chk("act", chan_active, {cfg[2][3], 1'b1, cfg[2][2], 1'b1, cfg[2][1], 3'h7});
        // Strobe off, read-only target and unmapped place
        host_inst.wr(8'h39, ~d, 4'h0);
        host_inst.rd(8'h39, {24'h0, cfg[0]}, 1'b0);
        host_inst.wr(8'h37, 32'hFF, 4'hF);
        host_inst.rd(8'h37, 32'h0, 1'b0);
        host_inst.rd(8'h50, 32'h0, 1'b1);
        $display("test config done");
        // Limit 50, hysteresis 5, two readings to trip
        for (int i = 0; i < 8; i++) lim.limit[i] <= 8'd50;
        lim.hyst <= 8'd5;
        lim.consec <= 4'd2;
        host_inst.wr(8'h3B, 32'h0E, 4'hF);
        exp8 = 8'h00;
        for (int c = 0; c < 8; c++) begin
            rdg(c, 8'd60);
            chk("flags", critical_flags, exp8);
            rdg(c, 8'd60);
            exp8[c] = 1'b1;
            chk("flags", critical_flags, exp8);
            chk("sum", critical_summary, 1'b1);
        end
        host_inst.rd(8'h37, 32'hFF, 1'b0);
        host_inst.rd(8'h37, 32'hFF, 1'b0);
        host_inst.rd(8'h02, 32'h2, 1'b0);
        rdg(7, 8'd45);
        chk("flags", critical_flags, 8'hFF);
        rdg(7, 8'd44);
        chk("flags", critical_flags, 8'h7F);
        for (int c = 0; c < 7; c++) begin
            chk("sum", critical_summary, 1'b1);
            rdg(c, 8'd40);
        end
        chk("sum", critical_summary, 1'b0);
        // Unpaired channels ignore readings
        host_inst.wr(8'h3B, 32'h00, 4'hF);
        for (int c = 3; c < 8; c += 2) begin
            rdg(c, 8'd90);
            rdg(c, 8'd90);
        end
        chk("flags", critical_flags, 8'h00);
        $display("test critical done");
        // Hottest-of, remember and pairs on, then both off
        @(posedge pclk);
        for (int i = 0; i < 8; i++) meas.temp[i] <= {tv[i], 3'h0};
        for (int p = 0; p < 2; p++) begin
            host_inst.wr(8'h3B, p ? 32'h00 : 32'h8E, 4'hF);
            rem = 8'h00;
            act = p ? 8'h57 : 8'hFF;
            for (int k = 0; k < 7; k++) begin
                sel = sels[k];
                host_inst.wr(8'h3A, {24'h0, sel}, 4'hF);
                conv();
                oh = 8'h00;
                hi = tmlh_pkg::HOT_EMPTY_HI;
                for (int i = 0; i < 8; i++) begin
                    if (sel[i] && act[i] && (oh == 8'h00 || $signed(tv[i]) > $signed(hi))) begin
                        hi = tv[i];
                        oh = 8'h01 << i;
                    end
                end
                chg = (p == 0) && oh != 8'h00 && rem != 8'h00 && rem != oh;
                if (oh != 8'h00) rem = oh;
                chk("chg", max_changed, chg);
                // Hottest bytes
                host_inst.rd(8'h32, {24'h0, hi}, 1'b0);
                host_inst.rd(8'h34, {24'h0, oh}, 1'b0);
                host_inst.rd(8'h02, {31'h0, chg}, 1'b0);
            end
        end
        $display("test hottest done");
        end_sim();
    end
endmodule
